// ===== src/sensorless_commutation_controller.sv
// Sensorless commutation controller: estimator, PI loop, startup sequencer
`timescale 1ns/1ps
module sensorless_commutation_controller #(
    parameter int MS_TICKS_US = sc_pkg::US_PER_MS
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic start_in,
    input wire logic [2:0] bemf_cmp_in,
    input wire logic drive_shape_select_in,
    input wire logic [4:0] sense_window_width_in,
    input wire logic [2:0] sense_windows_per_cycle_in,
    input wire logic advance_mode_select_in,
    input wire logic [5:0] advance_angle_in,
    input wire logic signed [7:0] measured_lead_in,
    input wire logic [1:0] auto_advance_gain_in,
    input wire logic [3:0] steady_prop_gain_in,
    input wire logic [3:0] steady_integ_gain_in,
    input wire logic [3:0] transient_prop_gain_in,
    input wire logic [3:0] transient_integ_gain_in,
    input wire logic [3:0] low_speed_limit_in,
    input wire logic [3:0] over_speed_limit_in,
    input wire logic [15:0] target_speed_hz_in,
    input wire logic [3:0] align_time_in,
    input wire logic coast_enable_in,
    input wire logic [15:0] ramp_start_hz_in,
    input wire logic [15:0] ramp_end_hz_in,
    input wire logic [7:0] ramp_inc_hz_in,
    input wire logic speed_loop_enable_in,
    input wire logic restart_on_loss_in,
    input wire logic clear_lost_in,
    output logic [15:0] elec_angle_out,
    output logic [2:0] phase_float_out,
    output logic drive_enable_out,
    output logic [15:0] speed_hz_out,
    output logic transient_out,
    output logic closed_loop_out,
    output logic speed_loop_active_out,
    output logic lost_sync_out
);
    // Sector number of an electrical angle
    function automatic logic [2:0] sector_of(input logic [15:0] a);
        logic [2:0] s;
        s = 3'h0;
        for (int i = 1; i < 6; i++) begin
            if ({16'h0000, a} >= 32'(i) * {16'h0000, sc_pkg::ANGLE_60}) begin
                s = 3'(i);
            end
        end
        return s;
    endfunction

    // Start angle of a sector
    function automatic logic [15:0] sector_base(input logic [2:0] s);
        return 16'({13'h0000, s} * sc_pkg::ANGLE_60);
    endfunction

    // Phase left undriven in each trapezoidal sector
    function automatic logic [2:0] float_mask(input logic [2:0] s);
        logic [2:0] m;
        case (s)
            3'h0, 3'h3: m = 3'h1;
            3'h1, 3'h4: m = 3'h4;
            default: m = 3'h2;
        endcase
        return m;
    endfunction

    // Saturate a signed speed into the unsigned 16-bit range
    function automatic logic [15:0] clamp_freq(input logic signed [18:0] v);
        logic [15:0] r;
        if (v < 0) begin
            r = 16'h0000;
        end else if (v > 19'sh0FFFF) begin
            r = 16'hFFFF;
        end else begin
            r = v[15:0];
        end
        return r;
    endfunction

    logic [2:0] cmp_stable;
    pin_sync #(.WIDTH(sc_pkg::CMP_W)) u_cmp_sync (
        .mclk_in(mclk_in),
        .srst_in(srst_in),
        .async_in(bemf_cmp_in),
        .stable_out(cmp_stable)
    );

    sc_pkg::stage_t stage_reg, stage_next;
    logic [sc_pkg::TICK_CNT_W-1:0] tick_cnt_reg, tick_cnt_next;
    logic [sc_pkg::US_CNT_W-1:0] us_cnt_reg, us_cnt_next;
    logic [31:0] acc_reg, acc_next;
    logic [15:0] freq_reg, freq_next;
    logic [15:0] timer_reg, timer_next;
    logic [2:0] events_reg, events_next;
    logic [2:0] sector_reg, sector_next;
    logic [2:0] cmp_prev_reg, cmp_prev_next;
    logic [2:0] win_cnt_reg, win_cnt_next;
    logic detected_reg, detected_next;
    logic win_seen_reg, win_seen_next;
    logic signed [15:0] auto_off_reg, auto_off_next;
    logic [2:0] float_next;
    logic drive_next, transient_next, lost_next;

    logic us_tick, ms_tick, loop_on, sensing, edge_seen, detect, comm_point;
    logic [15:0] angle, pos, zc_pos, width, win_lo, win_hi, diff, offset;
    logic [2:0] sector, fmask, win_limit;
    logic [3:0] kp, ki;
    logic signed [16:0] err;
    logic signed [21:0] prod_p, prod_i;
    logic signed [16:0] delta;

    // Timebase enables; angle and sensing window geometry
    always_comb begin
        us_tick = (tick_cnt_reg == sc_pkg::TICK_LAST);
        ms_tick = us_tick && (us_cnt_reg == sc_pkg::US_CNT_W'(MS_TICKS_US - 1));
        angle = acc_reg[31:16];
        sector = sector_of(angle);
        pos = angle - sector_base(sector);
        fmask = float_mask(sector);
        if (advance_mode_select_in == sc_pkg::ADV_MANUAL) begin
            offset = {10'h000, advance_angle_in} * sc_pkg::WIN_STEP;
        end else begin
            offset = auto_off_reg[15:0];
        end
        zc_pos = sc_pkg::ANGLE_30 + offset;
        if (zc_pos >= sc_pkg::ANGLE_60) begin
            zc_pos = sc_pkg::ANGLE_60 - 16'h0001;
        end
        width = {11'h000, sense_window_width_in} * sc_pkg::WIN_STEP;
        win_lo = (zc_pos > width) ? zc_pos - width : 16'h0000;
        win_hi = zc_pos + (width >> 1);
        if (sense_window_width_in == sc_pkg::WIN_FULL_CODE) begin
            win_lo = 16'h0000;
            win_hi = sc_pkg::ANGLE_60;
        end
        // Zero requests every sector so sensing can never be switched off
        win_limit = (sense_windows_per_cycle_in == 3'h0 ||
                     sense_windows_per_cycle_in > sc_pkg::SECTORS) ?
                    sc_pkg::SECTORS : sense_windows_per_cycle_in;
    end

    // Crossing detection and loop error
    always_comb begin
        loop_on = (stage_reg == sc_pkg::ST_COAST) ||
                  (stage_reg == sc_pkg::ST_RUN);
        if (drive_shape_select_in == sc_pkg::DRIVE_TRAP) begin
            sensing = 1'b1;
        end else begin
            sensing = (pos >= win_lo) && (pos < win_hi) &&
                      (win_cnt_reg < win_limit);
        end
        edge_seen = |((cmp_stable ^ cmp_prev_reg) & fmask);
        detect = loop_on && sensing && edge_seen && !detected_reg;
        comm_point = (sector != sector_reg);
        kp = transient_out ? transient_prop_gain_in
                           : steady_prop_gain_in;
        ki = transient_out ? transient_integ_gain_in
                           : steady_integ_gain_in;
        err = $signed({1'b0, zc_pos}) - $signed({1'b0, pos});
        prod_p = err * $signed({1'b0, kp});
        prod_i = err * $signed({1'b0, ki});
        diff = (freq_reg > target_speed_hz_in) ?
               freq_reg - target_speed_hz_in : target_speed_hz_in - freq_reg;
        delta = ($signed({11'h000, advance_angle_in}) -
                 17'(measured_lead_in)) <<< auto_advance_gain_in;
    end

    // Sequencer, estimator and loop next-state
    always_comb begin
        stage_next = stage_reg;
        tick_cnt_next = us_tick ? '0 : tick_cnt_reg + 1'b1;
        us_cnt_next = ms_tick ? '0 : (us_tick ? us_cnt_reg + 1'b1 : us_cnt_reg);
        acc_next = acc_reg;
        freq_next = freq_reg;
        timer_next = ms_tick ? timer_reg + 16'h0001 : timer_reg;
        events_next = events_reg;
        sector_next = sector;
        cmp_prev_next = cmp_stable;
        win_cnt_next = win_cnt_reg;
        detected_next = detected_reg;
        win_seen_next = win_seen_reg || sensing;
        auto_off_next = auto_off_reg;
        drive_next = drive_enable_out;
        transient_next = transient_out;
        // A new loss wins over a clear in the same cycle
        lost_next = clear_lost_in ? 1'b0 : lost_sync_out;
        if (us_tick && stage_reg != sc_pkg::ST_ALIGN) begin
            acc_next = acc_reg + 32'(freq_reg) * sc_pkg::PHASE_INC_PER_HZ;
        end
        if (comm_point) begin
            detected_next = 1'b0;
            win_seen_next = 1'b0;
            win_cnt_next = (win_cnt_reg == sc_pkg::SECTORS - 3'h1) ?
                           3'h0 : win_cnt_reg + 3'h1;
        end
        case (stage_reg)
            sc_pkg::ST_IDLE: begin
                drive_next = 1'b0;
                if (start_in) begin
                    stage_next = sc_pkg::ST_PRECHECK;
                    timer_next = 16'h0000;
                    events_next = 3'h0;
                end
            end
            sc_pkg::ST_PRECHECK: begin
                drive_next = 1'b0;
                if (|(cmp_stable ^ cmp_prev_reg) &&
                    events_reg != 3'h7) begin
                    events_next = events_reg + 3'h1;
                end
                if (events_reg >= sc_pkg::PRECHECK_EDGES) begin
                    // Already turning: skip align and ramp, sync by coasting
                    stage_next = sc_pkg::ST_COAST;
                    freq_next = ramp_start_hz_in;
                    events_next = 3'h0;
                end else if (timer_reg >= sc_pkg::PRECHECK_MS_CNT) begin
                    timer_next = 16'h0000;
                    acc_next = sc_pkg::ACC_RESET;
                    if (align_time_in != 4'h0) begin
                        stage_next = sc_pkg::ST_ALIGN;
                        drive_next = 1'b1;
                    end else begin
                        stage_next = sc_pkg::ST_RAMP;
                        drive_next = 1'b1;
                        freq_next = ramp_start_hz_in;
                    end
                end
            end
            sc_pkg::ST_ALIGN: begin
                freq_next = sc_pkg::FREQ_RESET;
                if (timer_reg >= {12'h000, align_time_in} *
                                 sc_pkg::ALIGN_STEP_MS) begin
                    stage_next = sc_pkg::ST_RAMP;
                    timer_next = 16'h0000;
                    freq_next = ramp_start_hz_in;
                end
            end
            sc_pkg::ST_RAMP: begin
                if (freq_reg >= ramp_end_hz_in) begin
                    events_next = 3'h0;
                    if (coast_enable_in) begin
                        stage_next = sc_pkg::ST_COAST;
                        drive_next = 1'b0;
                    end else begin
                        stage_next = sc_pkg::ST_RUN;
                    end
                end else if (ms_tick) begin
                    freq_next = clamp_freq($signed({3'b000, freq_reg}) +
                                $signed({11'h000, ramp_inc_hz_in}));
                end
            end
            sc_pkg::ST_COAST, sc_pkg::ST_RUN: begin
                if (detect) begin
                    detected_next = 1'b1;
                    // Proportional term pulls phase, integral pulls speed
                    acc_next = acc_next +
                               {16'(prod_p >>> sc_pkg::PROP_SHIFT), 16'h0000};
                    freq_next = clamp_freq($signed({3'b000, freq_reg}) +
                                19'(prod_i >>> sc_pkg::INTEG_SHIFT));
                    if (events_reg != 3'h7) begin
                        events_next = events_reg + 3'h1;
                    end
                    if (freq_next > {12'h000, over_speed_limit_in} *
                                    sc_pkg::OVER_STEP_HZ) begin
                        stage_next = sc_pkg::ST_LOST;
                    end
                end else if (comm_point && win_seen_reg && !detected_reg) begin
                    // A missed crossing slows the sequence, and below the low speed limit declares loss
                    freq_next = clamp_freq($signed({3'b000, freq_reg}) -
                                $signed({15'h0000, kp}));
                    if (freq_next < {12'h000, low_speed_limit_in} *
                                    sc_pkg::LOW_STEP_HZ) begin
                        stage_next = sc_pkg::ST_LOST;
                    end
                end
                if (stage_reg == sc_pkg::ST_COAST &&
                    events_reg >= sc_pkg::COAST_SYNC_EVENTS &&
                    stage_next != sc_pkg::ST_LOST) begin
                    stage_next = sc_pkg::ST_RUN;
                    drive_next = 1'b1;
                end
                if (stage_reg == sc_pkg::ST_RUN && comm_point &&
                    advance_mode_select_in == sc_pkg::ADV_AUTO) begin
                    // Offset kept within half a sector to stay in the window
                    auto_off_next = auto_off_reg + delta[15:0];
                    if (auto_off_next < 0) begin
                        auto_off_next = 16'sh0000;
                    end else if (auto_off_next > $signed(sc_pkg::ANGLE_30)) begin
                        auto_off_next = $signed(sc_pkg::ANGLE_30);
                    end
                end
                if (!transient_out && diff > sc_pkg::ENTER_TRANSIENT_HZ) begin
                    transient_next = 1'b1;
                end else if (transient_out &&
                             diff < sc_pkg::LEAVE_TRANSIENT_HZ) begin
                    transient_next = 1'b0;
                end
                if (stage_next == sc_pkg::ST_LOST) begin
                    lost_next = 1'b1;
                    drive_next = 1'b0;
                    freq_next = sc_pkg::FREQ_RESET;
                end
            end
            sc_pkg::ST_LOST: begin
                drive_next = 1'b0;
                transient_next = 1'b0;
                if (restart_on_loss_in && start_in) begin
                    stage_next = sc_pkg::ST_PRECHECK;
                    timer_next = 16'h0000;
                    events_next = 3'h0;
                end else if (!start_in) begin
                    stage_next = sc_pkg::ST_IDLE;
                end
            end
            default: begin
                stage_next = sc_pkg::ST_IDLE;
            end
        endcase
        if (!start_in && stage_reg != sc_pkg::ST_LOST) begin
            stage_next = sc_pkg::ST_IDLE;
            drive_next = 1'b0;
            freq_next = sc_pkg::FREQ_RESET;
        end
        // Sine drive floats the phase only inside the window
        if (drive_shape_select_in == sc_pkg::DRIVE_TRAP || !drive_next) begin
            float_next = drive_next ? float_mask(sector_of(acc_next[31:16]))
                                    : 3'h7;
        end else begin
            float_next = sensing ? fmask : 3'h0;
        end
    end

    // State registers
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            stage_reg <= sc_pkg::ST_IDLE;
            tick_cnt_reg <= '0;
            us_cnt_reg <= '0;
            acc_reg <= sc_pkg::ACC_RESET;
            freq_reg <= sc_pkg::FREQ_RESET;
            timer_reg <= 16'h0000;
            events_reg <= 3'h0;
            sector_reg <= 3'h0;
            cmp_prev_reg <= 3'h0;
            win_cnt_reg <= 3'h0;
            detected_reg <= 1'b0;
            win_seen_reg <= 1'b0;
            auto_off_reg <= 16'sh0000;
            phase_float_out <= 3'h7;
            drive_enable_out <= 1'b0;
            transient_out <= 1'b0;
            lost_sync_out <= 1'b0;
            elec_angle_out <= 16'h0000;
            speed_hz_out <= 16'h0000;
            closed_loop_out <= 1'b0;
            speed_loop_active_out <= 1'b0;
        end else begin
            stage_reg <= stage_next;
            tick_cnt_reg <= tick_cnt_next;
            us_cnt_reg <= us_cnt_next;
            acc_reg <= acc_next;
            freq_reg <= freq_next;
            timer_reg <= timer_next;
            events_reg <= events_next;
            sector_reg <= sector_next;
            cmp_prev_reg <= cmp_prev_next;
            win_cnt_reg <= win_cnt_next;
            detected_reg <= detected_next;
            win_seen_reg <= win_seen_next;
            auto_off_reg <= auto_off_next;
            phase_float_out <= float_next;
            drive_enable_out <= drive_next;
            transient_out <= transient_next;
            lost_sync_out <= lost_next;
            elec_angle_out <= acc_next[31:16];
            speed_hz_out <= freq_next;
            closed_loop_out <= (stage_next == sc_pkg::ST_RUN);
            speed_loop_active_out <= (stage_next == sc_pkg::ST_RUN) &&
                                     speed_loop_enable_in;
        end
    end
endmodule // sensorless_commutation_controller

// ===== src/sc_pkg.sv
// Shared constants and types for the sensorless commutation controller
package sc_pkg;
    // Clock and timebase
    localparam int CLK_HZ = 50_000_000;
    localparam int TICK_NS = 1000;
    localparam int TICK_CYCLES = (TICK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int TICK_CNT_W = 6;
    localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(TICK_CYCLES - 1);
    localparam int US_PER_MS = 1000;
    localparam int US_CNT_W = 10;

    // Startup timing
    localparam int PRECHECK_MS = 300;
    localparam logic [15:0] PRECHECK_MS_CNT = 16'(PRECHECK_MS);
    localparam logic [2:0] PRECHECK_EDGES = 3'h3;
    localparam logic [2:0] COAST_SYNC_EVENTS = 3'h3;
    localparam logic [15:0] ALIGN_STEP_MS = 16'h000A;

    // Electrical angle, 65536 units per electrical cycle
    localparam logic [15:0] ANGLE_60 = 16'h2AAB;
    localparam logic [15:0] ANGLE_30 = 16'h1555;
    localparam logic [15:0] WIN_STEP = 16'h00FF;
    localparam logic [4:0] WIN_FULL_CODE = 5'h1F;
    localparam logic [2:0] SECTORS = 3'h6;
    localparam logic [31:0] PHASE_INC_PER_HZ = 32'h000010C7;

    // Loop tuning
    localparam logic [15:0] ENTER_TRANSIENT_HZ = 16'h000A;
    localparam logic [15:0] LEAVE_TRANSIENT_HZ = 16'h0005;
    localparam logic [15:0] LOW_STEP_HZ = 16'h000A;
    localparam logic [15:0] OVER_STEP_HZ = 16'h0100;
    localparam int PROP_SHIFT = 4;
    localparam int INTEG_SHIFT = 8;

    // Mode encodings
    localparam logic DRIVE_SINE = 1'b0;
    localparam logic DRIVE_TRAP = 1'b1;
    localparam logic ADV_MANUAL = 1'b0;
    localparam logic ADV_AUTO = 1'b1;

    // Reset values
    localparam logic [31:0] ACC_RESET = 32'h00000000;
    localparam logic [15:0] FREQ_RESET = 16'h0000;
    localparam int CMP_W = 3;

    typedef enum logic [2:0] {
        ST_IDLE, ST_PRECHECK, ST_ALIGN, ST_RAMP, ST_COAST, ST_RUN, ST_LOST
    } stage_t;
endpackage

// ===== src/pin_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 3
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] stable_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] stable_next;

    // A bit changes only once the second and third stages agree
    always_comb begin
        stable_next = stable_out;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                stable_next[i] = s3_reg[i];
            end
        end
    end

    // The first stage feeds only the second stage
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            stable_out <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            stable_out <= stable_next;
        end
    end
endmodule // pin_sync

// ===== tb/sc_checker_sva.sv
// Port-level assertions for the commutation controller
`timescale 1ns/1ps
module sc_checker (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic start_in,
    input wire logic drive_shape_select_in,
    input wire logic clear_lost_in,
    input wire logic [2:0] phase_float_out,
    input wire logic drive_enable_out,
    input wire logic closed_loop_out,
    input wire logic speed_loop_active_out,
    input wire logic lost_sync_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    // Three low edges leave room for the registered stage change
    sequence held_low;
        !start_in [*3];
    endsequence
    // Bridge and sensing relations
    a_off_all_float: assert property (
        !drive_enable_out |-> phase_float_out == 3'h7)
        else $error("float mask wrong with drive off");
    a_trap_one_float: assert property (
        drive_enable_out && drive_shape_select_in |-> $onehot(phase_float_out))
        else $error("trapezoid drive must float one phase");
    a_sine_few_float: assert property (
        drive_enable_out && !drive_shape_select_in
        |-> $countones(phase_float_out) <= 1)
        else $error("sine drive floats more than one phase");
    // Loss handling
    a_loss_stops_run: assert property (
        $rose(lost_sync_out) |-> !drive_enable_out && !closed_loop_out)
        else $error("loss did not stop the drive");
    a_loss_flag_held: assert property (
        lost_sync_out && !clear_lost_in |=> lost_sync_out)
        else $error("loss flag dropped without clear");
    // Startup sequencing
    a_run_drives_bridge: assert property (
        closed_loop_out |-> drive_enable_out)
        else $error("closed loop without drive");
    a_speed_loop_run: assert property (
        speed_loop_active_out |-> closed_loop_out)
        else $error("speed loop active outside run");
    a_stop_goes_idle: assert property (
        held_low |-> !closed_loop_out)
        else $error("run kept after start dropped");
endmodule // sc_checker

bind sensorless_commutation_controller sc_checker u_sc_checker (
    .mclk_in(mclk_in), .srst_in(srst_in), .start_in(start_in),
    .drive_shape_select_in(drive_shape_select_in),
    .clear_lost_in(clear_lost_in), .phase_float_out(phase_float_out),
    .drive_enable_out(drive_enable_out), .closed_loop_out(closed_loop_out),
    .speed_loop_active_out(speed_loop_active_out),
    .lost_sync_out(lost_sync_out));

// ===== tb/motor_bemf_model.sv
// Behavioural motor whose bemf comparators follow the driven field
`timescale 1ns/1ps
module motor_bemf_model (
    input wire logic mclk_in,
    input wire logic spinning_in,
    input wire logic [15:0] elec_angle_in,
    output logic [2:0] bemf_cmp_out
);
    logic [15:0] rotor_reg = 16'h0000;
    // Rotor only moves while driven, so a stopped bridge shows no edges
    always @(posedge mclk_in) begin
        if (spinning_in) rotor_reg <= elec_angle_in;
    end
    // Each comparator flips mid-way through its floating sectors
    assign bemf_cmp_out[0] = rotor_reg >= 16'h1555 && rotor_reg < 16'h9555;
    assign bemf_cmp_out[2] = rotor_reg >= 16'h4000 && rotor_reg < 16'hC000;
    assign bemf_cmp_out[1] = rotor_reg < 16'h6AAB || rotor_reg >= 16'hEAAB;
endmodule // motor_bemf_model

// ===== tb/sensorless_commutation_controller_tb.sv
// Directed startup and loss runs against the motor model
`timescale 1ns/1ps
module sensorless_commutation_controller_tb;
    logic mclk_in;
    logic srst_in = 1'b1;
    logic [7:0] ctl = 8'h00; // start,trap,auto,coast,sloop,restart,clear
    logic [15:0] ang;
    logic [15:0] spd;
    logic [2:0] flt;
    logic [2:0] bemf;
    logic drv, trans, closed, act, lost;
    logic [15:0] a0;
    logic [15:0] tgt = 16'h07D0;
    logic [15:0] r_start = 16'h07D0;
    logic [15:0] r_end = 16'h07D0;
    logic [4:0] win_w = 5'h1F;
    logic [3:0] kps = 4'h4, kis = 4'h4, kpt = 4'h4, kit = 4'h4;
    logic [3:0] lo_lim = 4'h1, hi_lim = 4'h1, align = 4'h0;
    int failures = 0;
    int cmp_count = 0;
    // One-us ms tick keeps the rotation check near 15k cycles
    sensorless_commutation_controller #(.MS_TICKS_US(1)) DUT (
        .mclk_in(mclk_in), .srst_in(srst_in), .start_in(ctl[0]),
        .bemf_cmp_in(bemf), .drive_shape_select_in(ctl[1]),
        .sense_window_width_in(win_w), .sense_windows_per_cycle_in(3'h6),
        .advance_mode_select_in(ctl[2]), .advance_angle_in(6'h00),
        .measured_lead_in(8'sh00), .auto_advance_gain_in(2'h0),
        .steady_prop_gain_in(kps), .steady_integ_gain_in(kis),
        .transient_prop_gain_in(kpt), .transient_integ_gain_in(kit),
        .low_speed_limit_in(lo_lim), .over_speed_limit_in(hi_lim),
        .target_speed_hz_in(tgt), .align_time_in(align),
        .coast_enable_in(ctl[3]), .ramp_start_hz_in(r_start),
        .ramp_end_hz_in(r_end), .ramp_inc_hz_in(8'h0A),
        .speed_loop_enable_in(ctl[4]), .restart_on_loss_in(ctl[5]),
        .clear_lost_in(ctl[6]), .elec_angle_out(ang), .phase_float_out(flt),
        .drive_enable_out(drv), .speed_hz_out(spd), .transient_out(trans),
        .closed_loop_out(closed), .speed_loop_active_out(act),
        .lost_sync_out(lost));
    motor_bemf_model motor (.mclk_in(mclk_in), .spinning_in(drv),
        .elec_angle_in(ang), .bemf_cmp_out(bemf));
    // Compare and count
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    function automatic logic pick(input int sel);
        pick = (sel == 0) ? drv : (sel == 1) ? closed : lost;
    endfunction
    // Bounded wait for drive, run or loss to rise
    task automatic wait_hi(input int sel, input int lim);
        int n;
        n = 0;
        while (pick(sel) !== 1'b1 && n < lim) begin
            @(posedge mclk_in);
            #1;
            n++;
        end
        check("awaited output", 16'h0001, 16'(pick(sel)));
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    // Watchdog spans three rotation checks plus margin
    initial begin
        repeat (70000) @(posedge mclk_in);
        failures++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge mclk_in);
        #1 srst_in = 1'b0;
        check("float after reset", 16'h0007, 16'(flt));
        check("flag after reset", 16'h0000, 16'(lost));
        ctl = 8'h17; // Auto with trapezoid drive assumed
        repeat (1000) @(posedge mclk_in);
        #1 check("drive in check", 16'h0000, 16'(drv));
        wait_hi(0, 35000);
        wait_hi(1, 2000);
        check("speed loop", 16'h0001, 16'(act));
        check("steady state", 16'h0000, 16'(trans));
        check("floats", 16'h0001, 16'($countones(flt)));
        wait_hi(2, 20000);
        a0 = ang;
        check("drive at loss", 16'h0000, 16'(drv));
        repeat (200) @(posedge mclk_in);
        #1 check("flag held", 16'h0001, 16'(lost));
        check("angle frozen", a0, ang);
        check("no restart", 16'h0000, 16'(drv));
        check("speed at loss", 16'h0000, spd);
        $display("test trapezoid overspeed done");
        ctl = 8'h50;
        repeat (5) @(posedge mclk_in);
        #1 ctl = 8'h10;
        check("flag cleared", 16'h0000, 16'(lost));
        check("float stopped", 16'h0007, 16'(flt));
        $display("test clear and stop done");
        // Align on, off-target speed and a narrow window for the sine run
        align = 4'h1;
        tgt = 16'h0700;
        win_w = 5'h08;
        ctl = 8'h31;
        wait_hi(0, 35000);
        repeat (400) @(posedge mclk_in);
        #1 check("run during align", 16'h0000, 16'(closed));
        wait_hi(1, 200);
        @(posedge mclk_in);
        #1 check("transient", 16'h0001, 16'(trans));
        check("sine outside window", 16'h0000, 16'(flt));
        wait_hi(2, 25000);
        repeat (20) @(posedge mclk_in);
        #1 check("back to check", 16'h0000, 16'(drv));
        wait_hi(0, 35000);
        check("flag kept", 16'h0001, 16'(lost));
        ctl = 8'h40;
        repeat (5) @(posedge mclk_in);
        #1 check("stopped", 16'h0000, 16'(closed));
        $display("test sine restart done");
        final_report();
    end
endmodule // sensorless_commutation_controller_tb
